/* File: hw/analog_input_acquisition.sv */
/*
  Acquisition core of an eight-channel analog input: standard values, end-of-cycle and
  limit interrupts, diagnostics, triggered capture buffer and per-channel wrap FIFOs.
  Assumes converter samples and host commands on clk; supply_ok is an asynchronous pin.
*/
`timescale 1ns/1ps
module analog_input_acquisition #(
  parameter int SCOPE_DEPTH = acq_pkg::SCOPE_DEPTH,
  parameter int FIFO_DEPTH = acq_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // converter
  input wire logic adc_valid,
  input wire logic [acq_pkg::CH_W-1:0] adc_chan,
  input wire logic signed [acq_pkg::RAW_W-1:0] adc_raw,
  // configuration
  input wire logic [1:0] mode,
  input wire logic param_ok,
  input wire logic [15:0] cycle_us,
  input wire logic eoc_int_en,
  input wire logic hi_int_en,
  input wire logic lo_int_en,
  input wire logic [15:0] hi_limit,
  input wire logic [15:0] lo_limit,
  input wire logic [1:0] trig_mode,
  input wire logic [acq_pkg::CH_W-1:0] trig_chan,
  input wire logic [15:0] trig_level,
  input wire logic supply_ok,
  // host commands
  input wire logic scope_start,
  input wire logic [acq_pkg::CH_W-1:0] val_chan,
  input wire logic buf_rd_req,
  input wire logic [acq_pkg::CH_W-1:0] buf_rd_chan,
  input wire logic pint_ack,
  input wire logic diag_clr,
  // host results
  output logic [15:0] val_q,
  output logic buf_rd_valid_q,
  output logic buf_rd_empty_q,
  output logic [15:0] buf_rd_data_q,
  output logic [acq_pkg::CH_W-1:0] buf_rd_tag_q,
  output logic [1:0] scope_state_q,
  output logic [acq_pkg::NCH-1:0] fifo_ovf_q,
  output logic pint_q,
  output logic [acq_pkg::ID_W-1:0] pint_data_q,
  output logic [acq_pkg::DG_W-1:0] diag_q
);
  localparam int NCH = acq_pkg::NCH;
  localparam int AW = $clog2(SCOPE_DEPTH);
  localparam int FW = $clog2(FIFO_DEPTH);
  localparam int EW = acq_pkg::CH_W + acq_pkg::CODE_W;

  sample_if s ();

  sample_scaler u_scaler (
    .clk(clk),
    .rstn(rstn),
    .in_valid(adc_valid),
    .in_chan(adc_chan),
    .in_raw(adc_raw),
    .param_ok(param_ok),
    .sp(s)
  );

  logic sup_s1_q, sup_s2_q;
  logic [15:0] vals_q [NCH];
  logic [15:0] vals_d [NCH];
  logic [NCH-1:0] seen_q, seen_d, chbit;
  logic eoc_ev, hi_ev, lo_ev, eoc_int, any_int, std_mode, scope_mode, fifo_mode;
  logic pint_d;
  logic [acq_pkg::ID_W-1:0] pint_data_d;
  logic [acq_pkg::DG_W-1:0] diag_d, diag_set;
  logic [15:0] val_d;
  logic [15:0] trig_prev_q, trig_prev_d;
  logic trig_prev_ok_q, trig_prev_ok_d, edge_hit;
  logic [1:0] scope_state_d;
  logic [AW:0] sc_wr_q, sc_wr_d, sc_rd_q, sc_rd_d;
  logic [FW-1:0] fwr_q [NCH];
  logic [FW-1:0] fwr_d [NCH];
  logic [FW-1:0] frd_q [NCH];
  logic [FW-1:0] frd_d [NCH];
  logic [FW:0] fcnt_q [NCH];
  logic [FW:0] fcnt_d [NCH];
  logic [NCH-1:0] fifo_ovf_d;
  logic [EW-1:0] mem [SCOPE_DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_wa, mem_ra;
  logic [EW-1:0] mem_wd, rd_word;
  logic rd_hit;
  logic buf_rd_valid_d, buf_rd_empty_d;
  logic [15:0] buf_rd_data_d;
  logic [acq_pkg::CH_W-1:0] buf_rd_tag_d;

  function automatic logic [FW-1:0] fifo_next(input logic [FW-1:0] p);
    fifo_next = (int'(p) == FIFO_DEPTH - 1) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [AW-1:0] fifo_addr(input logic [acq_pkg::CH_W-1:0] c,
                                               input logic [FW-1:0] p);
    fifo_addr = AW'(int'(c) * FIFO_DEPTH + int'(p));
  endfunction

  // supply pin synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sup_s1_q <= 1'b1;
      sup_s2_q <= 1'b1;
    end
    else
    begin
      sup_s1_q <= supply_ok;
      sup_s2_q <= sup_s1_q;
    end
  end

  // standard values, cycle tracking, interrupts and diagnostics
  always_comb
  begin
    std_mode = mode == acq_pkg::MODE_STD;
    scope_mode = mode == acq_pkg::MODE_SCOPE;
    fifo_mode = mode == acq_pkg::MODE_FIFO;
    chbit = NCH'(1) << s.chan;
    vals_d = vals_q;
    seen_d = seen_q;
    eoc_ev = 1'b0;
    if (s.valid)
    begin
      vals_d[s.chan] = s.code;
      if ((seen_q | chbit) == '1)
      begin
        eoc_ev = 1'b1;
        seen_d = '0;
      end
      else
      begin
        seen_d = seen_q | chbit;
      end
    end
    val_d = vals_q[val_chan];
    hi_ev = s.valid && hi_int_en && ($signed(s.code) > $signed(hi_limit));
    lo_ev = s.valid && lo_int_en && ($signed(s.code) < $signed(lo_limit));
    eoc_int = eoc_ev && eoc_int_en && (cycle_us >= acq_pkg::EOC_MIN_CYCLE_US);
    any_int = std_mode && (hi_ev || lo_ev || eoc_int);
    pint_d = pint_q && !pint_ack;
    pint_data_d = pint_data_q;
    diag_set = '0;
    if (any_int)
    begin
      pint_d = 1'b1;
      pint_data_d = '0;
      pint_data_d[acq_pkg::ID_OVER +: NCH] = hi_ev ? chbit : '0;
      pint_data_d[acq_pkg::ID_UNDER +: NCH] = lo_ev ? chbit : '0;
      pint_data_d[acq_pkg::ID_EOC] = eoc_int;
      diag_set[acq_pkg::DG_LOST] = pint_q && !pint_ack;
    end
    if (!std_mode)
    begin
      pint_d = 1'b0;
    end
    diag_set[acq_pkg::DG_PARAM] = !param_ok;
    diag_set[acq_pkg::DG_RANGE] = s.valid && (s.over || s.under);
    diag_set[acq_pkg::DG_SUPPLY] = !sup_s2_q;
    diag_d = (diag_clr ? '0 : diag_q) | diag_set;
  end

  // capture buffer and FIFOs share one sample memory
  always_comb
  begin
    scope_state_d = scope_state_q;
    sc_wr_d = sc_wr_q;
    sc_rd_d = sc_rd_q;
    trig_prev_d = trig_prev_q;
    trig_prev_ok_d = trig_prev_ok_q;
    fwr_d = fwr_q;
    frd_d = frd_q;
    fcnt_d = fcnt_q;
    fifo_ovf_d = diag_clr ? '0 : fifo_ovf_q;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = {s.chan, s.code};
    mem_ra = '0;
    rd_hit = 1'b0;
    edge_hit = 1'b0;
    if (s.valid && s.chan == trig_chan)
    begin
      trig_prev_d = s.code;
      trig_prev_ok_d = 1'b1;
      if (trig_prev_ok_q && trig_mode == acq_pkg::TRIG_RISE)
      begin
        edge_hit = $signed(trig_prev_q) < $signed(trig_level)
                   && $signed(s.code) >= $signed(trig_level);
      end
      else if (trig_prev_ok_q && trig_mode == acq_pkg::TRIG_FALL)
      begin
        edge_hit = $signed(trig_prev_q) >= $signed(trig_level)
                   && $signed(s.code) < $signed(trig_level);
      end
    end
    case (scope_state_q)
      acq_pkg::SC_IDLE, acq_pkg::SC_FULL:
      begin
        if (scope_start)
        begin
          sc_wr_d = '0;
          sc_rd_d = '0;
          scope_state_d = (trig_mode == acq_pkg::TRIG_MANUAL) ? acq_pkg::SC_REC
                                                              : acq_pkg::SC_ARMED;
        end
      end
      acq_pkg::SC_ARMED:
      begin
        if (edge_hit)
        begin
          mem_we = 1'b1;
          mem_wa = '0;
          sc_wr_d = (AW + 1)'(1);
          scope_state_d = acq_pkg::SC_REC;
        end
      end
      acq_pkg::SC_REC:
      begin
        if (s.valid)
        begin
          mem_we = 1'b1;
          mem_wa = sc_wr_q[AW-1:0];
          sc_wr_d = sc_wr_q + 1'b1;
          if (int'(sc_wr_q) == SCOPE_DEPTH - 1)
          begin
            scope_state_d = acq_pkg::SC_FULL;
          end
        end
      end
      default:
      begin
        scope_state_d = acq_pkg::SC_IDLE;
      end
    endcase
    if (scope_mode && buf_rd_req && sc_rd_q < sc_wr_q)
    begin
      rd_hit = 1'b1;
      mem_ra = sc_rd_q[AW-1:0];
      sc_rd_d = sc_rd_q + 1'b1;
    end
    if (fifo_mode && buf_rd_req && fcnt_q[buf_rd_chan] != '0)
    begin
      rd_hit = 1'b1;
      mem_ra = fifo_addr(buf_rd_chan, frd_q[buf_rd_chan]);
      frd_d[buf_rd_chan] = fifo_next(frd_q[buf_rd_chan]);
      fcnt_d[buf_rd_chan] = fcnt_q[buf_rd_chan] - 1'b1;
    end
    if (fifo_mode && s.valid)
    begin
      mem_we = 1'b1;
      mem_wa = fifo_addr(s.chan, fwr_q[s.chan]);
      fwr_d[s.chan] = fifo_next(fwr_q[s.chan]);
      if (int'(fcnt_d[s.chan]) == FIFO_DEPTH)
      begin
        frd_d[s.chan] = fifo_next(frd_d[s.chan]);
        fifo_ovf_d[s.chan] = 1'b1;
      end
      else
      begin
        fcnt_d[s.chan] = fcnt_d[s.chan] + 1'b1;
      end
    end
    if (!scope_mode)
    begin
      scope_state_d = acq_pkg::SC_IDLE;
    end
    if (!fifo_mode)
    begin
      fwr_d = '{default: '0};
      frd_d = '{default: '0};
      fcnt_d = '{default: '0};
    end
    rd_word = mem[mem_ra];
    buf_rd_valid_d = rd_hit;
    buf_rd_empty_d = buf_rd_req && !rd_hit;
    buf_rd_data_d = rd_hit ? rd_word[acq_pkg::CODE_W-1:0] : buf_rd_data_q;
    buf_rd_tag_d = rd_hit ? rd_word[EW-1 -: acq_pkg::CH_W] : buf_rd_tag_q;
  end

  // sample memory has no reset; only written entries are ever read
  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vals_q <= '{default: '0};
      seen_q <= '0;
      val_q <= '0;
      pint_q <= 1'b0;
      pint_data_q <= '0;
      diag_q <= '0;
      trig_prev_q <= '0;
      trig_prev_ok_q <= 1'b0;
      scope_state_q <= acq_pkg::SC_IDLE;
      sc_wr_q <= '0;
      sc_rd_q <= '0;
      fwr_q <= '{default: '0};
      frd_q <= '{default: '0};
      fcnt_q <= '{default: '0};
      fifo_ovf_q <= '0;
      buf_rd_valid_q <= 1'b0;
      buf_rd_empty_q <= 1'b0;
      buf_rd_data_q <= '0;
      buf_rd_tag_q <= '0;
    end
    else
    begin
      vals_q <= vals_d;
      seen_q <= seen_d;
      val_q <= val_d;
      pint_q <= pint_d;
      pint_data_q <= pint_data_d;
      diag_q <= diag_d;
      trig_prev_q <= trig_prev_d;
      trig_prev_ok_q <= trig_prev_ok_d;
      scope_state_q <= scope_state_d;
      sc_wr_q <= sc_wr_d;
      sc_rd_q <= sc_rd_d;
      fwr_q <= fwr_d;
      frd_q <= frd_d;
      fcnt_q <= fcnt_d;
      fifo_ovf_q <= fifo_ovf_d;
      buf_rd_valid_q <= buf_rd_valid_d;
      buf_rd_empty_q <= buf_rd_empty_d;
      buf_rd_data_q <= buf_rd_data_d;
      buf_rd_tag_q <= buf_rd_tag_d;
    end
  end
endmodule

/* File: hw/acq_pkg.sv */
/*
  Shared constants for the analog input acquisition block: code formats, scaling,
  saturation limits, buffer sizes, mode and trigger encodings.
  Assumes a converter that delivers signed raw samples with nominal full scale at 2**16.
*/
package acq_pkg;
  localparam int NCH = 8;
  localparam int CH_W = 3;
  localparam int CODE_W = 16;
  localparam int RAW_W = 18;
  // nominal full scale code and raw full-scale shift: code = raw * 27648 / 2**16
  localparam logic [15:0] FS_CODE = 16'h6C00;
  localparam int RAW_FS_SH = 16;
  // saturation codes and the ends of the over/underdrive regions
  localparam logic [15:0] CODE_MAX = 16'h7FFF;
  localparam logic [15:0] CODE_MIN = 16'h8000;
  localparam int OVER_TOP = 32511;
  localparam int UNDER_BOT = -32512;
  localparam int SIGN_BIT = 15;
  // buffers
  localparam int SCOPE_DEPTH = 65536;
  localparam int FIFO_DEPTH = 8190;
  // least cycle time for the end-of-cycle interrupt, in microseconds
  localparam logic [15:0] EOC_MIN_CYCLE_US = 16'h00C8;
  // diagnostic bit positions
  localparam int DG_PARAM = 0;
  localparam int DG_LOST = 1;
  localparam int DG_RANGE = 2;
  localparam int DG_SUPPLY = 3;
  localparam int DG_W = 4;
  // interrupt data byte lanes
  localparam int ID_OVER = 0;
  localparam int ID_UNDER = 8;
  localparam int ID_EOC = 16;
  localparam int ID_W = 32;

  typedef enum logic [1:0] {
    MODE_STD = 2'b00,
    MODE_SCOPE = 2'b01,
    MODE_FIFO = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    TRIG_MANUAL = 2'b00,
    TRIG_RISE = 2'b01,
    TRIG_FALL = 2'b10
  } trig_t;

  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_ARMED = 2'b01,
    SC_REC = 2'b10,
    SC_FULL = 2'b11
  } scope_state_t;
endpackage

/* File: hw/sample_if.sv */
/*
  Carrier for one formatted sample between the scaler and the acquisition core.
  Assumes both ends run on the same clock; valid is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface sample_if;
  logic valid;
  logic [acq_pkg::CH_W-1:0] chan;
  logic [acq_pkg::CODE_W-1:0] code;
  logic over;
  logic under;
  modport src (output valid, output chan, output code, output over, output under);
  modport dst (input valid, input chan, input code, input over, input under);
endinterface

/* File: hw/sample_scaler.sv */
/*
  Scales a raw converter sample to the 16-bit two's-complement code and saturates it.
  Assumes the raw sample comes from logic on the same clock, full scale at 2**16.
*/
`timescale 1ns/1ps
module sample_scaler #(
  parameter int RAW_W = acq_pkg::RAW_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // raw sample
  input wire logic in_valid,
  input wire logic [acq_pkg::CH_W-1:0] in_chan,
  input wire logic signed [RAW_W-1:0] in_raw,
  input wire logic param_ok,
  // formatted sample
  sample_if.src sp
);
  logic signed [RAW_W+16:0] prod;
  logic signed [RAW_W-1:0] scaled;
  logic over_c;
  logic under_c;
  logic valid_d;
  logic [acq_pkg::CH_W-1:0] chan_d;
  logic [acq_pkg::CODE_W-1:0] code_d;
  logic over_d;
  logic under_d;

  // same scale for the voltage and the current range: full scale gives 27648
  always_comb
  begin
    prod = in_raw * $signed({1'b0, acq_pkg::FS_CODE});
    scaled = prod[acq_pkg::RAW_FS_SH +: RAW_W];
    over_c = int'(scaled) > acq_pkg::OVER_TOP;
    under_c = int'(scaled) < acq_pkg::UNDER_BOT;
    valid_d = in_valid;
    chan_d = in_chan;
    over_d = in_valid && over_c;
    under_d = in_valid && under_c;
    if (!param_ok)
    begin
      code_d = acq_pkg::CODE_MAX;
    end
    else if (over_c)
    begin
      code_d = acq_pkg::CODE_MAX;
    end
    else if (under_c)
    begin
      code_d = acq_pkg::CODE_MIN;
    end
    else
    begin
      code_d = scaled[acq_pkg::CODE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sp.valid <= 1'b0;
      sp.chan <= '0;
      sp.code <= '0;
      sp.over <= 1'b0;
      sp.under <= 1'b0;
    end
    else
    begin
      sp.valid <= valid_d;
      sp.chan <= chan_d;
      sp.code <= code_d;
      sp.over <= over_d;
      sp.under <= under_d;
    end
  end
endmodule

/* File: verif/acq_chk.sv */
/*
  Port-level properties of the acquisition block.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module acq_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // inputs watched
  input wire logic [1:0] mode,
  input wire logic supply_ok,
  input wire logic scope_start,
  input wire logic buf_rd_req,
  input wire logic pint_ack,
  input wire logic diag_clr,
  // outputs watched
  input wire logic buf_rd_valid_q,
  input wire logic buf_rd_empty_q,
  input wire logic [1:0] scope_state_q,
  input wire logic [acq_pkg::NCH-1:0] fifo_ovf_q,
  input wire logic pint_q,
  input wire logic [acq_pkg::ID_W-1:0] pint_data_q,
  input wire logic [acq_pkg::DG_W-1:0] diag_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_no_int; (mode != 2'b00) [*2] |-> !pint_q; endproperty
  a_no_int: assert property (p_no_int) else $error("interrupt outside standard mode");
  property p_int_hold; pint_q && !pint_ack && mode == 2'b00 ##1 mode == 2'b00 |-> pint_q;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped unacked");
  property p_int_data; pint_q |-> pint_data_q[31:17] == 15'h0000 && pint_data_q != 32'h0;
  endproperty
  a_int_data: assert property (p_int_data) else $error("bad interrupt data");
  property p_full_hold;
    scope_state_q == 2'b11 && !scope_start && mode == 2'b01 |=> scope_state_q == 2'b11;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("capture left full");
  property p_scope_idle; (mode != 2'b01) [*2] |-> scope_state_q == 2'b00; endproperty
  a_scope_idle: assert property (p_scope_idle) else $error("capture active off mode");
  property p_rd_cause;
    buf_rd_valid_q || buf_rd_empty_q |-> $past(buf_rd_req) && !(buf_rd_valid_q && buf_rd_empty_q);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
  property p_diag_sticky; !diag_clr |=> (diag_q & $past(diag_q)) == $past(diag_q); endproperty
  a_diag_sticky: assert property (p_diag_sticky) else $error("diag bit lost");
  property p_ovf_sticky;
    !diag_clr |=> (fifo_ovf_q & $past(fifo_ovf_q)) == $past(fifo_ovf_q);
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
  property p_supply; !supply_ok [*5] |-> diag_q[3]; endproperty
  a_supply: assert property (p_supply) else $error("missing supply not flagged");
  c_full: cover property (scope_state_q == 2'b11);
  c_ovf: cover property (fifo_ovf_q != 8'h00);
  c_int: cover property ($rose(pint_q));
  c_rd: cover property (buf_rd_valid_q);
endmodule

bind analog_input_acquisition acq_chk u_chk (.clk, .rstn, .mode, .supply_ok, .scope_start,
  .buf_rd_req, .pint_ack, .diag_clr, .buf_rd_valid_q, .buf_rd_empty_q, .scope_state_q,
  .fifo_ovf_q, .pint_q, .pint_data_q, .diag_q);

/* File: verif/host_model.sv */
/*
  Host side: acknowledges a pending process interrupt, at once or after a wait.
  Assumes the block's clock and reset; the bench sets ack_en and slow.
*/
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench control
  input wire logic ack_en,
  input wire logic slow,
  // interrupt handshake
  input wire logic pint_q,
  output logic pint_ack
);
  logic [2:0] wait_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_q <= 3'h0;
      pint_ack <= 1'b0;
    end
    else
    begin
      pint_ack <= pint_q && ack_en && !pint_ack && (!slow || wait_q == 3'h4);
      wait_q <= (pint_q && ack_en && !pint_ack && wait_q != 3'h4) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule

/* File: verif/analog_input_acquisition_test.sv */
/*
  Self-checking bench for the acquisition block with small buffer depths.
  Assumes the host model for acknowledges and the bound checker.
*/
`timescale 1ns/1ps
module analog_input_acquisition_test;
  localparam int SD = 64;
  localparam int FD = 8;
  logic clk = 0, rstn = 0, adc_valid = 0, param_ok = 1, eoc_int_en = 0, hi_int_en = 0;
  logic lo_int_en = 0, supply_ok = 1, scope_start = 0, buf_rd_req = 0, diag_clr = 0;
  logic ack_en = 0, slow = 0, pint_ack, buf_rd_valid_q, buf_rd_empty_q, pint_q;
  logic [2:0] adc_chan = 3'h0, trig_chan = 3'h1, val_chan = 3'h0, buf_rd_chan = 3'h0;
  logic [2:0] buf_rd_tag_q;
  logic signed [17:0] adc_raw = 18'h00000;
  logic [1:0] mode = 2'h0, trig_mode = 2'h0, scope_state_q;
  logic [15:0] cycle_us = 16'h0064, hi_limit = 16'h7FFF, lo_limit = 16'h8000;
  logic [15:0] trig_level = 16'h0000, val_q, buf_rd_data_q;
  logic [7:0] fifo_ovf_q;
  logic [31:0] pint_data_q;
  logic [3:0] diag_q;
  int err_count = 0, checks_done = 0;
  always #2 clk = ~clk;
  analog_input_acquisition #(.SCOPE_DEPTH(SD), .FIFO_DEPTH(FD)) DUT (.clk, .rstn, .adc_valid,
    .adc_chan, .adc_raw, .mode, .param_ok, .cycle_us, .eoc_int_en, .hi_int_en, .lo_int_en,
    .hi_limit, .lo_limit, .trig_mode, .trig_chan, .trig_level, .supply_ok, .scope_start,
    .val_chan, .buf_rd_req, .buf_rd_chan, .pint_ack, .diag_clr, .val_q, .buf_rd_valid_q,
    .buf_rd_empty_q, .buf_rd_data_q, .buf_rd_tag_q, .scope_state_q, .fifo_ovf_q, .pint_q,
    .pint_data_q, .diag_q);
  host_model HOST (.clk, .rstn, .ack_en, .slow, .pint_q, .pint_ack);
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_start();
    scope_start = 1;
    tick(1);
    scope_start = 0;
    tick(1);
  endtask
  // one converter sample, strobe lowered a cycle before the next one
  task automatic smp(logic [2:0] ch, int r);
    adc_valid = 1;
    adc_chan = ch;
    adc_raw = r[17:0];
    tick(1);
    adc_valid = 0;
    tick(1);
  endtask
  function automatic logic [15:0] cv(longint r);
    longint c;
    c = (r * 27648) >>> 16;
    if (!param_ok || c > 32511) return 16'h7FFF;
    if (c < -32512) return 16'h8000;
    return c[15:0];
  endfunction
  // valid and empty stand for one cycle only: judged just after the request edge
  task automatic rd(logic [2:0] ch, logic hit, logic [15:0] d, logic [2:0] t);
    buf_rd_req = 1;
    buf_rd_chan = ch;
    tick(1);
    buf_rd_req = 0;
    chk("rd_flags", {buf_rd_valid_q, buf_rd_empty_q}, {hit, !hit});
    if (hit) chk("rd_word", {buf_rd_tag_q, buf_rd_data_q}, {t, d});
    tick(1);
  endtask
  task automatic t_scale();
    int tbl[8] = '{65536, -65536, 32768, -32768, 77065, 77067, 131071, -131072};
    for (int k = 0; k < 8; k++)
    begin
      val_chan = k[2:0];
      smp(k[2:0], tbl[k]);
      tick(2);
      chk("val", val_q, cv(tbl[k]));
    end
  endtask
  task automatic t_diag();
    param_ok = 0;
    val_chan = 3'h4;
    smp(3'h4, 1000);
    tick(2);
    chk("val_bad", val_q, 16'h7FFF);
    chk("diag_par_rng", {diag_q[0], diag_q[2]}, 2'h3);
    param_ok = 1;
    supply_ok = 0;
    tick(6);
    chk("diag_sup", diag_q[3], 1'b1);
    supply_ok = 1;
    tick(4);
    diag_clr = 1;
    tick(1);
    diag_clr = 0;
    tick(1);
    chk("diag_clr", diag_q, 4'h0);
  endtask
  task automatic t_int();
    int i;
    cycle_us = 16'h00C8;
    eoc_int_en = 1;
    for (int k = 0; k < 8; k++) smp(k[2:0], 0);
    for (i = 0; i < 20 && pint_q !== 1'b1; i++) tick(1);
    chk("pint_wait", i < 20, 1'b1);
    if (i == 20) finish_test();
    chk("pint_eoc", pint_data_q, 32'h00010000);
    hi_int_en = 1;
    hi_limit = 16'h0000;
    smp(3'h2, 4096);
    tick(2);
    chk("pint_hi", pint_data_q, 32'h00000004);
    chk("lost", diag_q[1], 1'b1);
    ack_en = 1;
    slow = 1;
    hi_int_en = 0;
    tick(12);
    chk("acked", pint_q, 1'b0);
    cycle_us = 16'h00C7;
    for (int k = 0; k < 8; k++) smp(k[2:0], 0);
    tick(3);
    chk("eoc_short", pint_q, 1'b0);
    eoc_int_en = 0;
    slow = 0;
    lo_int_en = 1;
    lo_limit = 16'h0000;
    smp(3'h5, -4096);
    tick(2);
    chk("pint_lo", pint_data_q, 32'h00002000);
    lo_int_en = 0;
  endtask
  task automatic t_bufs();
    mode = 2'b10;
    hi_int_en = 1;
    for (int k = 0; k < 4; k++) smp(3'h6, k * 256);
    for (int k = 0; k < 4; k++) rd(3'h6, 1, 16'(k * 108), 3'h6);
    for (int k = 0; k < FD + 2; k++) smp(3'h3, k * 256);
    tick(3);
    chk("ovf", fifo_ovf_q, 8'h08);
    chk("no_int", pint_q, 1'b0);
    for (int k = 2; k < FD + 2; k++) rd(3'h3, 1, 16'(k * 108), 3'h3);
    rd(3'h3, 0, 16'h0000, 3'h0);
    mode = 2'b01;
    hi_int_en = 0;
    trig_mode = 2'b00;
    pulse_start();
    chk("rec_man", scope_state_q, 2'b10);
    for (int k = 0; k < SD + 4; k++) smp(k[2:0], k * 256);
    tick(3);
    chk("full", scope_state_q, 2'b11);
    for (int k = 0; k < SD; k++) rd(3'h0, 1, 16'(k * 108), k[2:0]);
    rd(3'h0, 0, 16'h0000, 3'h0);
  endtask
  task automatic t_trig(logic [1:0] tm, int r0, int r1);
    mode = 2'b00;
    tick(2);
    mode = 2'b01;
    trig_mode = tm;
    pulse_start();
    chk("armed", scope_state_q, 2'b01);
    smp(3'h1, r0);
    smp(3'h0, r1);
    tick(2);
    chk("still_armed", scope_state_q, 2'b01);
    smp(3'h1, r1);
    tick(2);
    chk("rec_edge", scope_state_q, 2'b10);
    rd(3'h0, 1, cv(r1), 3'h1);
  endtask
  initial
  begin
    tick(5);
    rstn = 1;
    tick(1);
    t_scale();
    t_diag();
    t_int();
    t_bufs();
    t_trig(2'b01, -256, 256);
    t_trig(2'b10, 256, -256);
    finish_test();
  end
endmodule
